/* src/option_byte_config_loader.sv */
// option byte configuration loader: fetches both option bytes at reset and
// drives the configuration enables of the surrounding units
// assumes programmer writes arrive synchronous to clk_sys
`timescale 1ns/1ns
`include "optcfg_map.svh"
module option_byte_config_loader (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // programmer side
  input  wire logic                  prog_mode,
  input  wire logic                  prog_wr,
  input  wire optcfg_pkg::opt_word_t prog_data,
  // unit requests that settings qualify
  input  wire logic                  idle_exec,
  input  wire logic                  conv_start_bit,
  input  wire logic                  stop_req,
  input  wire logic                  watchdog_active,
  input  wire logic                  nmi_pin,
  input  wire logic                  supply_low,
  input  wire logic                  readout_req,
  // status
  output logic                       cfg_valid,
  output optcfg_pkg::opt_word_t      prog_readback,
  // decoded settings
  output logic                       conv_on_idle_sel,
  output logic                       frame_11bit_en,
  output logic                       ext_halt_ctl,
  output logic                       undervolt_reset_en,
  output logic                       readout_protect_en,
  output logic                       osc_type_sel,
  output logic                       port_pullup_dis,
  output logic                       nmi_pin_pullup_en,
  output logic                       timer_pin_pullup_en,
  output logic                       watchdog_hw_activation,
  output logic                       osc_guard_en,
  // qualified actions
  output logic                       conv_start,
  output logic                       stop_allow,
  output logic                       undervolt_reset,
  output logic                       readout_grant
);
  import optcfg_pkg::*;

  // ****************************************
  // option storage
  // ****************************************
  optcfg_if stor_bus ();
  optcfg_store u_store (
    .clk_sys (clk_sys),
    .port    (stor_bus.store)
  );
  // writes only accepted in programming mode, whole word, no address
  assign stor_bus.wr_en   = prog_mode && prog_wr;
  assign stor_bus.wr_data = prog_data;

  // ****************************************
  // fetch sequence
  // ****************************************
  load_state_t state_ff;
  load_state_t nxt_state;
  logic [1:0]  cnt_ff;
  logic [1:0]  nxt_cnt;
  opt_word_t   word_ff;
  wire         fetch_done = (cnt_ff == `OPT_CNT_ONE);
  wire         in_run     = (state_ff == ST_RUN);

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_FETCH: begin
        nxt_cnt = cnt_ff - `OPT_CNT_ONE;
        if (fetch_done) begin
          nxt_state = ST_APPLY;
        end
      end
      ST_APPLY: nxt_state = ST_RUN;
      ST_RUN:   nxt_state = ST_RUN;
      default:  nxt_state = ST_FETCH;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= ST_FETCH;
      cnt_ff   <= `OPT_FETCH_CYCLES;
      word_ff  <= `OPT_WORD_RESET;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      // the word is captured once; later programming only shows after reset
      if (state_ff == ST_FETCH && fetch_done) begin
        word_ff <= stor_bus.rd_data;
      end
    end
  end

  // ****************************************
  // decoded settings and qualified actions
  // ****************************************
  // named fields of the captured word; reserved positions are stored but never read
  wire bit_conv_sync = word_ff[`OPT_BIT_CONV_SYNC];
  wire bit_frame11   = word_ff[`OPT_BIT_FRAME11];
  wire bit_ext_halt  = word_ff[`OPT_BIT_EXT_HALT];
  wire bit_undervolt = word_ff[`OPT_BIT_UNDERVOLT];
  wire bit_protect   = word_ff[`OPT_BIT_PROTECT];
  wire bit_osc_type  = word_ff[`OPT_BIT_OSC_TYPE];
  wire bit_port_pull = word_ff[`OPT_BIT_PORT_PULL];
  wire bit_nmi_pull  = word_ff[`OPT_BIT_NMI_PULL];
  wire bit_timer_pin_pullup_en  = word_ff[`OPT_BIT_TIMER_PIN_PULLUP_EN];
  wire bit_wdg_act   = word_ff[`OPT_BIT_WDG_ACT];
  wire bit_osc_guard = word_ff[`OPT_BIT_OSC_GUARD];
  // settings only move in the apply cycle, then hold until reset
  wire apply_now     = (state_ff == ST_APPLY);

  // selection for the qualified actions
  wire conv_go = bit_conv_sync ? idle_exec : conv_start_bit;
  wire stop_ok = !watchdog_active || (bit_ext_halt && nmi_pin);
  wire uv_go   = bit_undervolt && supply_low;
  wire read_ok = !bit_protect && readout_req;

  // ****************************************
  // status and readback
  // ****************************************
  // cfg_valid drops on every reset, so a unit never acts on a half-loaded set
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg_valid <= 1'h0;
    end else if (apply_now) begin
      cfg_valid <= 1'h1;
    end
  end

  // readback lags the store by one cycle; it shows new writes, the settings do not
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prog_readback <= `OPT_WORD_RESET;
    end else begin
      prog_readback <= stor_bus.rd_data;
    end
  end

  // ****************************************
  // settings latches
  // ****************************************
  // converter, serial frame, halt and undervoltage selections
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_on_idle_sel   <= 1'h0;
      frame_11bit_en     <= 1'h0;
      ext_halt_ctl       <= 1'h0;
      undervolt_reset_en <= 1'h0;
    end else if (apply_now) begin
      conv_on_idle_sel   <= bit_conv_sync;
      frame_11bit_en     <= bit_frame11;
      ext_halt_ctl       <= bit_ext_halt;
      undervolt_reset_en <= bit_undervolt;
    end
  end

  // protection, oscillator type and port pull-ups
  // protection defaults on until the word is applied, so readout is never open early
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readout_protect_en <= 1'h1;
      osc_type_sel       <= 1'h0;
      port_pullup_dis    <= 1'h0;
    end else if (apply_now) begin
      readout_protect_en <= bit_protect;
      osc_type_sel       <= bit_osc_type;
      port_pullup_dis    <= bit_port_pull;
    end
  end

  // pin pull-ups, watchdog activation and oscillator safeguard
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      nmi_pin_pullup_en      <= 1'h0;
      timer_pin_pullup_en    <= 1'h0;
      watchdog_hw_activation <= 1'h0;
      osc_guard_en           <= 1'h0;
    end else if (apply_now) begin
      nmi_pin_pullup_en      <= bit_nmi_pull;
      timer_pin_pullup_en    <= bit_timer_pin_pullup_en;
      watchdog_hw_activation <= bit_wdg_act;
      osc_guard_en           <= bit_osc_guard;
    end
  end

  // ****************************************
  // qualified actions
  // ****************************************
  // held off until settings are valid; each action costs one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      conv_start      <= 1'h0;
      stop_allow      <= 1'h0;
      undervolt_reset <= 1'h0;
      readout_grant   <= 1'h0;
    end else begin
      conv_start      <= in_run && conv_go;
      stop_allow      <= in_run && stop_req && stop_ok;
      undervolt_reset <= in_run && uv_go;
      readout_grant   <= in_run && read_ok;
    end
  end
endmodule : option_byte_config_loader

/* src/optcfg_map.svh */
// constants for the option byte configuration loader
// assumes inclusion by bare name from design files
`ifndef OPTCFG_MAP_SVH
`define OPTCFG_MAP_SVH
// upper byte fields
`define OPT_BIT_CONV_SYNC   4'hc
`define OPT_BIT_FRAME11     4'hb
`define OPT_BIT_EXT_HALT    4'h9
`define OPT_BIT_UNDERVOLT   4'h8
// lower byte fields
`define OPT_BIT_PROTECT     4'h7
`define OPT_BIT_OSC_TYPE    4'h6
`define OPT_BIT_PORT_PULL   4'h5
`define OPT_BIT_NMI_PULL    4'h3
`define OPT_BIT_TIMER_PIN_PULLUP_EN    4'h2
`define OPT_BIT_WDG_ACT     4'h1
`define OPT_BIT_OSC_GUARD   4'h0
// reset value of the non-volatile word before any programming
`define OPT_WORD_RESET      16'h0000
// cycles spent in the fetch phase after reset
`define OPT_FETCH_CYCLES    2'h2
`define OPT_CNT_ZERO        2'h0
`define OPT_CNT_ONE         2'h1
`endif

/* src/optcfg_pkg.sv */
// types of the option byte configuration loader
// assumes nothing beyond a synthesis tool with package support
package optcfg_pkg;
  typedef enum logic [2:0] {
    ST_FETCH = 3'h1,
    ST_APPLY = 3'h2,
    ST_RUN   = 3'h4
  } load_state_t;
  typedef logic [15:0] opt_word_t;
endpackage : optcfg_pkg

/* src/optcfg_if.sv */
// carrier between the loader and its option storage
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface optcfg_if;
  logic                 wr_en;
  optcfg_pkg::opt_word_t wr_data;
  optcfg_pkg::opt_word_t rd_data;
  modport store (input wr_en, input wr_data, output rd_data);
  modport user  (output wr_en, output wr_data, input rd_data);
endinterface : optcfg_if

/* src/optcfg_store.sv */
// non-volatile option word model: holds both option bytes
// assumes writes only arrive through the programming-mode gate
`timescale 1ns/1ns
`include "optcfg_map.svh"
module optcfg_store (
  input wire logic clk_sys,
  optcfg_if.store  port
);
  import optcfg_pkg::*;
  // contents survive chip reset, so no reset term here
  opt_word_t mem_ff = `OPT_WORD_RESET;
  always_ff @(posedge clk_sys) begin
    if (port.wr_en) begin
      mem_ff <= port.wr_data;
    end
  end
  assign port.rd_data = mem_ff;
endmodule : optcfg_store

/* tb/optcfg_programmer.sv */
// programmer model: writes one option word per request
// assumes req is raised for one cycle just after an edge
`timescale 1ns/1ns
module optcfg_programmer (
  input  wire logic                  clk_sys,
  input  wire logic                  req,
  input  wire logic                  no_mode,
  input  wire optcfg_pkg::opt_word_t word,
  output optcfg_pkg::opt_word_t      prog_data,
  output logic                       prog_mode,
  output logic                       prog_wr
);
  initial {prog_mode, prog_wr, prog_data} = '0;
  // idle data toggles so a stale word never looks valid
  always @(posedge clk_sys) begin
    prog_mode <= #1 req & ~no_mode;
    prog_wr   <= #1 req;
    prog_data <= #1 req ? (word & 16'h1bef) : ~prog_data;
  end
endmodule : optcfg_programmer

/* tb/option_byte_config_loader_monitor.sv */
// checker on the loader ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module option_byte_config_loader_monitor (
  input wire logic clk_sys, rst, prog_mode, prog_wr, idle_exec, conv_start_bit, stop_req,
  input wire logic watchdog_active, nmi_pin, supply_low, readout_req, cfg_valid,
  input wire logic conv_on_idle_sel, ext_halt_ctl, undervolt_reset_en, readout_protect_en,
  input wire logic conv_start, stop_allow, undervolt_reset, readout_grant,
  input wire optcfg_pkg::opt_word_t prog_data, prog_readback
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // protected while the bytes are not yet applied
  a_reset_safe_state: assert property (disable iff (1'b0) rst |=> readout_protect_en && !cfg_valid)
    else $error("reset state not safe");
  a_fetch_then_valid: assert property ($fell(rst) |-> !cfg_valid ##[1:4] cfg_valid)
    else $error("settings not applied in time");
  a_settings_held: assert property (cfg_valid |=> cfg_valid && $stable({conv_on_idle_sel, ext_halt_ctl,
    undervolt_reset_en, readout_protect_en}))
    else $error("settings moved without reset");
  a_conv_source: assert property (cfg_valid |=> conv_start == $past(conv_on_idle_sel ? idle_exec : conv_start_bit))
    else $error("conversion start wrong");
  a_stop_gate: assert property (cfg_valid |=> stop_allow ==
    $past(stop_req & (!watchdog_active | (ext_halt_ctl & nmi_pin))))
    else $error("stop permission wrong");
  a_undervolt_gate: assert property (cfg_valid |=> undervolt_reset == $past(undervolt_reset_en & supply_low))
    else $error("undervoltage reset wrong");
  a_readout_gate: assert property (cfg_valid |=> readout_grant == $past(!readout_protect_en & readout_req))
    else $error("readout grant wrong");
  a_write_readback: assert property (prog_mode && prog_wr |-> ##2 prog_readback == $past(prog_data, 2))
    else $error("written word not stored");
endmodule : option_byte_config_loader_monitor
bind option_byte_config_loader option_byte_config_loader_monitor i_mon (.clk_sys, .rst, .prog_mode, .prog_wr,
  .idle_exec, .conv_start_bit, .stop_req, .watchdog_active, .nmi_pin, .supply_low, .readout_req, .cfg_valid,
  .conv_on_idle_sel, .ext_halt_ctl, .undervolt_reset_en, .readout_protect_en, .conv_start, .stop_allow,
  .undervolt_reset, .readout_grant, .prog_data, .prog_readback);

/* tb/testbench.sv */
// self-checking bench for the option byte loader
// assumes the programmer model and the bound checker
`timescale 1ns/1ns
module testbench;
  import optcfg_pkg::*;
  logic clk_sys, rst, req, no_mode, idle_exec, conv_start_bit, stop_req, watchdog_active, nmi_pin;
  logic supply_low, readout_req, prog_mode, prog_wr, cfg_valid, conv_on_idle_sel, frame_11bit_en;
  logic ext_halt_ctl, undervolt_reset_en, readout_protect_en, osc_type_sel, port_pullup_dis;
  logic nmi_pin_pullup_en, timer_pin_pullup_en, watchdog_hw_activation, osc_guard_en;
  logic conv_start, stop_allow, undervolt_reset, readout_grant;
  logic [6:0] act, a;
  opt_word_t  word, prog_data, prog_readback, w, old;
  int         fail_count, compares;
  wire [10:0] sets = {conv_on_idle_sel, frame_11bit_en, ext_halt_ctl, undervolt_reset_en, readout_protect_en,
    osc_type_sel, port_pullup_dis, nmi_pin_pullup_en, timer_pin_pullup_en, watchdog_hw_activation, osc_guard_en};
  assign {idle_exec, conv_start_bit, stop_req, watchdog_active, nmi_pin, supply_low, readout_req} = act;
  option_byte_config_loader i_dut (.clk_sys, .rst, .prog_mode, .prog_wr, .prog_data, .idle_exec,
    .conv_start_bit, .stop_req, .watchdog_active, .nmi_pin, .supply_low, .readout_req, .cfg_valid,
    .prog_readback, .conv_on_idle_sel, .frame_11bit_en, .ext_halt_ctl, .undervolt_reset_en,
    .readout_protect_en, .osc_type_sel, .port_pullup_dis, .nmi_pin_pullup_en, .timer_pin_pullup_en,
    .watchdog_hw_activation, .osc_guard_en, .conv_start, .stop_allow, .undervolt_reset, .readout_grant);
  optcfg_programmer i_prog (.clk_sys, .req, .no_mode, .word, .prog_data, .prog_mode, .prog_wr);
  function automatic logic [10:0] dec(opt_word_t v);
    return {v[12:11], v[9:5], v[3:0]};
  endfunction : dec
  function automatic logic [3:0] exp_act(opt_word_t v, logic [6:0] x);
    return {v[12] ? x[6] : x[5], x[4] & (!x[3] | (v[9] & x[2])), v[8] & x[1], !v[7] & x[0]};
  endfunction : exp_act
  task automatic check(string name, opt_word_t got, opt_word_t exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // one write through the programmer, then wait until readback is due
  task automatic put(opt_word_t v, logic nm);
    @(posedge clk_sys) #1 {req, no_mode, word} = {1'b1, nm, v};
    @(posedge clk_sys) #1 req = 0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : put
  task automatic wait_valid;
    for (int k = 0; k < 10 && cfg_valid !== 1'b1; k++) @(posedge clk_sys) #1;
  endtask : wait_valid
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    #100000 fail_count++;
    summarize();
  end
  initial begin
    {rst, req, no_mode, act, word, fail_count, compares, old} = '0;
    rst = 1;
    void'($urandom(32'hdfc4));
    repeat (6) @(posedge clk_sys);
    #1 rst = 0;
    wait_valid();
    put(16'h1bef, 1);
    check("refused", prog_readback, 16'h0000);
    $display("test refused done");
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($urandom);
      put(w, 0);
      check("readback", prog_readback, w & 16'h1bef);
      check("held", sets, dec(old));
      @(posedge clk_sys) #1 rst = 1;
      @(posedge clk_sys) #1 rst = 0;
      check("in_reset", {cfg_valid, readout_protect_en}, 2'b01);
      wait_valid();
      check("settings", {cfg_valid, sets}, {1'b1, dec(w)});
      repeat (20) begin
        a = 7'($urandom);
        act = a;
        @(posedge clk_sys) #1;
        check("actions", {conv_start, stop_allow, undervolt_reset, readout_grant}, exp_act(w, a));
      end
      old = w;
      $display("test %0d done", i);
    end
    summarize();
  end
endmodule : testbench
